// [dpram_host.sv]
// Purpose: drives one port of an asynchronous dual-port RAM from a request port
// Assumes: wait and mailbox flags arrive asynchronously, data lines shared per port
// Notes: BANKS devices in depth; a secondary arbitrating device is gated by wait
`include "dpram_host_cfg.svh"
`timescale 1ns/1ps
module dpram_host
   import dpram_host_pkg::*;
#(
   parameter int BANK_BITS = 1,
   parameter bit IS_LEFT = 1'b1,
   parameter int ACCESS_CYC = `ACCESS_CYC,
   parameter int WPULSE_CYC = `WPULSE_CYC,
   parameter int SETTLE_CYC = `SETTLE_CYC,
   parameter int RECOVER_CYC = `RECOVER_CYC
) (
   input wire logic mclk, // 125 MHz clock
   input wire logic reset_n, // async reset, active low
   input wire logic req_valid, // request present
   input wire logic req_write, // 1 write, 0 read
   input wire logic [`ADDR_W+BANK_BITS-1:0] req_addr, // bank bits above word address
   input wire logic [`WORD_W-1:0] req_wdata, // write data
   output logic req_ready, // request taken when high with valid
   output logic rsp_valid, // one-cycle pulse at completion
   output logic [`WORD_W-1:0] rsp_rdata, // read data, held until next read
   output logic mail_pending, // own mailbox flag seen low
   output logic [(1<<BANK_BITS)-1:0] cs_n, // chip select per device
   output logic [(1<<BANK_BITS)-1:0] cs_aux_n, // chip select of secondary device
   output logic rw_sel, // high read, low write
   output logic oe_n, // output drive, active low
   output logic [`ADDR_W-1:0] address, // word address to every device
   output logic [`WORD_W-1:0] data_out, // data lines, driven value
   output logic data_oe, // data lines enable, high drives
   input wire logic [`WORD_W-1:0] data_in, // data lines, sampled value
   input wire logic wait_n, // master wait flag, active low
   input wire logic mail_n // own mailbox flag, active low
);
   localparam int BANKS = 1 << BANK_BITS;

   host_state_t state_reg;
   logic [`CNT_W-1:0] cnt_reg;
   logic write_reg;
   logic [BANK_BITS-1:0] bank_reg;
   logic [1:0] flags_s;
   logic wait_s;

   // flags are asynchronous to mclk
   flag_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .d({mail_n, wait_n}),
      .q(flags_s)
   );
   assign wait_s = flags_s[0];

   function automatic logic [`CNT_W-1:0] cyc(input int n);
      cyc = (n < 1) ? `CNT_W'(1) : `CNT_W'(n);
   endfunction

   // active-low one-hot chip select for a device number
   function automatic logic [BANKS-1:0] bank_sel_n(input logic [BANK_BITS-1:0] b);
      bank_sel_n = ~(BANKS'(1) << b);
   endfunction

   // sequencing of the port strobes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= '0;
         write_reg <= 1'b0;
         bank_reg <= '0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  write_reg <= req_write;
                  bank_reg <= req_addr[`ADDR_W+BANK_BITS-1:`ADDR_W];
                  cnt_reg <= cyc(SETTLE_CYC + 2);
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               // allow arbitration and synchroniser to settle
               if (cnt_reg > `CNT_W'(1)) begin
                  cnt_reg <= cnt_reg - `CNT_W'(1);
               end else begin
                  state_reg <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (wait_s) begin
                  cnt_reg <= write_reg ? cyc(WPULSE_CYC) : cyc(ACCESS_CYC);
                  state_reg <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (!wait_s) begin
                  state_reg <= ST_HOLD;
               end else if (cnt_reg > `CNT_W'(1)) begin
                  cnt_reg <= cnt_reg - `CNT_W'(1);
               end else begin
                  cnt_reg <= cyc(RECOVER_CYC);
                  state_reg <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               if (cnt_reg > `CNT_W'(1)) begin
                  cnt_reg <= cnt_reg - `CNT_W'(1);
               end else begin
                  state_reg <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               rsp_valid <= 1'b1;
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // address and data lines
   // held unchanged from take to release
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         address <= '0;
         data_out <= '0;
         data_oe <= 1'b0;
      end else begin
         if (state_reg == ST_IDLE && req_valid && req_ready) begin
            address <= req_addr[`ADDR_W-1:0];
            data_out <= req_wdata;
            data_oe <= req_write;
         end else if (state_reg == ST_RELEASE) begin
            data_oe <= 1'b0;
         end
      end
   end

   // control strobes
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cs_n <= '1;
         rw_sel <= 1'b1;
         oe_n <= 1'b1;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               rw_sel <= 1'b1;
               oe_n <= 1'b1;
               if (req_valid && req_ready) begin
                  cs_n <= bank_sel_n(req_addr[`ADDR_W+BANK_BITS-1:`ADDR_W]);
               end else begin
                  cs_n <= '1;
               end
            end
            ST_SETUP: begin
               // selected, strobes idle while wait settles
               cs_n <= bank_sel_n(bank_reg);
               rw_sel <= 1'b1;
               oe_n <= 1'b1;
            end
            ST_HOLD: begin
               cs_n <= bank_sel_n(bank_reg);
               rw_sel <= 1'b1;
               oe_n <= 1'b1;
               if (wait_s) begin
                  rw_sel <= ~write_reg;
                  oe_n <= write_reg;
               end
            end
            ST_STROBE: begin
               cs_n <= bank_sel_n(bank_reg);
               // wait mid-strobe drops both strobes; the access restarts in full
               if (!wait_s) begin
                  rw_sel <= 1'b1;
                  oe_n <= 1'b1;
               end
            end
            ST_RECOVER: begin
               cs_n <= bank_sel_n(bank_reg);
               rw_sel <= 1'b1;
            end
            ST_RELEASE: begin
               // winner releases the contention by raising chip select
               cs_n <= '1;
               rw_sel <= 1'b1;
               oe_n <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // secondary arbitrating device kept out while master reports wait
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cs_aux_n <= '1;
      end else begin
         cs_aux_n <= cs_n | {BANKS{~wait_s}};
      end
   end

   // read capture and mailbox status
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_rdata <= '0;
         mail_pending <= 1'b0;
      end else begin
         // read data taken on the last strobe cycle, before output drive lifts
         if (state_reg == ST_STROBE && !write_reg && wait_s && cnt_reg == `CNT_W'(1)) begin
            rsp_rdata <= data_in;
         end
         mail_pending <= ~flags_s[1];
      end
   end
endmodule

// [dpram_host_cfg.svh]
// Purpose: constants for the dual-port RAM port controller
// Assumes: 125 MHz mclk, asynchronous RAM with active-low strobes
// Notes: time figures are plain defaults, counts derive from them
// Contract
// - read: select high, chip select low, then address, then output drive low
// - read data valid after access time; end by raising output drive, chip select (code raises both on the same edge, in release)
// - write: chip select low, address and data, pulse select low, raise chip select
// - hold the pending operation while wait is low; start when it returns high
// - deeper memory: decode top address bits into per-device chip selects
// - in width expansion exactly one device arbitrates contention
// - with arbitrating secondaries, force their chip select high while master wait low
// - wait stays low until winner changes address or raises chip select
`ifndef DPRAM_HOST_CFG_SVH
`define DPRAM_HOST_CFG_SVH
`define WORD_W 8
`define ADDR_W 10
`define MBOX_TO_RIGHT 10'h3FF
`define MBOX_TO_LEFT 10'h3FE
`define CLK_MHZ 125
`define ACCESS_NS 100
`define WPULSE_NS 60
`define SETTLE_NS 24
`define RECOVER_NS 16
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define ACCESS_CYC `NS_TO_CYC(`ACCESS_NS)
`define WPULSE_CYC `NS_TO_CYC(`WPULSE_NS)
`define SETTLE_CYC `NS_TO_CYC(`SETTLE_NS)
`define RECOVER_CYC `NS_TO_CYC(`RECOVER_NS)
`define CNT_W 8
`endif

// [dpram_host_pkg.sv]
// Purpose: types for the dual-port RAM port controller
// Assumes: nothing
// Notes: state encoding left to tools
package dpram_host_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_HOLD,
      ST_STROBE,
      ST_RECOVER,
      ST_RELEASE
   } host_state_t;
endpackage

// [flag_sync.sv]
// Purpose: two-flop synchroniser for asynchronous flag inputs
// Assumes: inputs are levels
// Notes: reset value chosen per bit
`timescale 1ns/1ps
module flag_sync #(
   parameter int W = 2,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic mclk, // clock
   input wire logic reset_n, // async reset
   input wire logic [W-1:0] d, // async levels
   output logic [W-1:0] q // synchronised levels
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// [dpram_dev_model.sv]
// Purpose: behavioural two-bank RAM as seen from the left port
// Assumes: bank 0 holds the mailbox flags in use
// Notes: far port shows up only as contention and mailbox events
`timescale 1ns/1ps
module dpram_dev_model (
   input wire logic [1:0] cs_n, // chip selects
   input wire logic rw_sel, // high read
   input wire logic oe_n, // output drive
   input wire logic [9:0] address, // word address
   input wire logic [7:0] data_out, // host value
   input wire logic data_oe, // host drives
   input wire logic contend, // far port on same word
   input wire logic far_mail, // far port writes 3FE
   input wire logic far_read, // far port reads 3FF
   output logic [7:0] data_in, // line level
   output logic wait_n, // wait flag
   output logic mail_n = 1'b1, // own mailbox flag
   output logic far_mail_n = 1'b1 // far mailbox flag
);
   logic [7:0] mem [0:2047];
   logic [7:0] last = 8'h00;
   wire sel = ~&cs_n;
   wire [10:0] wa = {cs_n[0], address};
   wire rd = sel && rw_sel && !oe_n;
   assign wait_n = !(contend && sel);
   // released lines show the inverse of the last read
   assign data_in = data_oe ? data_out : rd ? mem[wa] : ~last;
   always @* if (rd) last = mem[wa];
   // a write lands as the select returns high, unless wait holds it off
   always @(posedge rw_sel) begin
      if (sel && wait_n) mem[wa] <= data_oe ? data_out : ~last;
   end
   always @(posedge rw_sel or posedge far_read) begin
      if (far_read) far_mail_n <= 1'b1;
      else if (sel && wait_n && !cs_n[0] && address == 10'h3FF) far_mail_n <= 1'b0;
   end
   always @(posedge far_mail or posedge rd) begin
      if (rd && !cs_n[0] && address == 10'h3FE) mail_n <= 1'b1;
      else if (far_mail) mail_n <= 1'b0;
   end
endmodule

// [dpram_host_chk.sv]
// Purpose: port-level checks on the RAM port controller
// Assumes: flags pass a two-flop synchroniser
// Notes: bound into every controller instance
`include "dpram_host_cfg.svh"
`timescale 1ns/1ps
module dpram_host_chk #(
   parameter int BANK_BITS = 1
) (
   input wire logic mclk, // clock
   input wire logic reset_n, // async reset
   input wire logic mail_pending, // mailbox status
   input wire logic [(1<<BANK_BITS)-1:0] cs_n, // chip selects
   input wire logic [(1<<BANK_BITS)-1:0] cs_aux_n, // gated selects
   input wire logic rw_sel, // high read
   input wire logic oe_n, // output drive
   input wire logic [`ADDR_W-1:0] address, // word address
   input wire logic data_oe, // data drive
   input wire logic wait_n, // wait flag
   input wire logic mail_n // mailbox flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   AST_ONE_BANK: assert property ($countones(~cs_n) <= 1)
      else $error("more than one chip select low");
   AST_READ_DRIVE: assert property (!oe_n |-> rw_sel && !data_oe && !(&cs_n))
      else $error("output drive without read setup");
   AST_WRITE_FORM: assert property (!rw_sel |-> oe_n && data_oe && !(&cs_n))
      else $error("write strobe without write setup");
   AST_HOLD_ON_WAIT: assert property (!wait_n [*5] |-> rw_sel && oe_n)
      else $error("strobe active while wait low");
   AST_ADDR_HOLD: assert property (!(&cs_n) && $stable(cs_n) |-> $stable(address))
      else $error("address moved during access");
   AST_GAP: assert property ($rose(&cs_n) |=> &cs_n)
      else $error("no idle cycle between accesses");
   AST_AUX_GATE: assert property (!wait_n [*4] |-> &cs_aux_n)
      else $error("secondary select low while wait low");
   AST_MAIL_SEEN: assert property (!mail_n [*4] |-> mail_pending)
      else $error("mailbox flag not reported");
   AST_MAIL_CLEAR: assert property (mail_n [*4] |-> !mail_pending)
      else $error("mailbox status stuck");
   cover property (!wait_n [*4] ##1 wait_n);
   cover property ($fell(oe_n));
   cover property ($fell(rw_sel));
   cover property ($rose(mail_pending));
endmodule
bind dpram_host dpram_host_chk #(.BANK_BITS(BANK_BITS)) chk_u (.mclk(mclk), .reset_n(reset_n),
   .mail_pending(mail_pending), .cs_n(cs_n), .cs_aux_n(cs_aux_n), .rw_sel(rw_sel), .oe_n(oe_n),
   .address(address), .data_oe(data_oe), .wait_n(wait_n), .mail_n(mail_n));

// [tb.sv]
// Purpose: self-checking bench for the RAM port controller
// Assumes: left-side controller, two banks, device model on the pins
// Notes: lfsr traffic plus mailbox and contention cases
`timescale 1ns/1ps
module tb;
   logic mclk = 0, reset_n = 0, req_valid = 0, req_write = 0, contend = 0, far_mail = 0;
   logic [10:0] req_addr = '0, a;
   logic [7:0] req_wdata = '0, rsp_rdata, data_out, data_in, q, shadow [0:2047];
   logic req_ready, rsp_valid, mail_pending, rw_sel, oe_n, data_oe, wait_n, mail_n, early;
   logic far_mail_n, far_read = 0;
   logic [1:0] cs_n, cs_aux_n;
   logic [9:0] address;
   logic [31:0] lfsr;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   always #4 mclk = ~mclk;
   dpram_host dut_u (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mail_pending(mail_pending), .cs_n(cs_n),
      .cs_aux_n(cs_aux_n), .rw_sel(rw_sel), .oe_n(oe_n), .address(address),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .wait_n(wait_n), .mail_n(mail_n));
   dpram_dev_model dev_u (.cs_n(cs_n), .rw_sel(rw_sel), .oe_n(oe_n), .address(address),
      .data_out(data_out), .data_oe(data_oe), .contend(contend), .far_mail(far_mail),
      .far_read(far_read), .data_in(data_in), .wait_n(wait_n), .mail_n(mail_n),
      .far_mail_n(far_mail_n));
   function logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // hold counts cycles of contention before the far port lets go
   task xfer(input logic wr, input logic [10:0] ad, input logic [7:0] d, input int hold);
      int n;
      n = 0;
      early = 0;
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      if (n == 200) begin
         fail_count++;
         $display("MISMATCH %0t request never taken", $time);
      end
      req_valid = 1;
      req_write = wr;
      req_addr = ad;
      req_wdata = d;
      @(negedge mclk);
      req_valid = 0;
      if (wr) shadow[ad] = d;
      repeat (hold) begin
         @(negedge mclk);
         early |= rsp_valid;
      end
      contend = 0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      if (n == 400) begin
         fail_count++;
         $display("MISMATCH %0t response never came", $time);
      end
      q = rsp_rdata;
      @(negedge mclk);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(negedge mclk);
      reset_n = 1;
      for (int p = 0; p < 2; p++) begin
         lfsr = 32'h5B60;
         for (int i = 0; i < 10; i++) begin
            lfsr = nxt(lfsr);
            a = (i == 0) ? 11'h7FD : (i == 1) ? 11'h000 : {lfsr[10], 1'b0, lfsr[8:0]};
            xfer(p == 0, a, lfsr[23:16], 0);
            if (p == 1) chk(q, shadow[a]);
         end
      end
      far_mail = 1;
      @(negedge mclk);
      far_mail = 0;
      repeat (4) @(negedge mclk);
      chk(mail_pending, 8'h01);
      xfer(1, 11'h7FE, 8'h3C, 0);
      xfer(0, 11'h7FE, 8'h00, 0);
      repeat (4) @(negedge mclk);
      chk(mail_pending, 8'h01);
      xfer(1, 11'h3FF, 8'h5A, 0);
      chk(far_mail_n, 8'h00);
      far_read = 1;
      @(negedge mclk);
      far_read = 0;
      chk(far_mail_n, 8'h01);
      xfer(0, 11'h3FE, 8'h00, 0);
      repeat (4) @(negedge mclk);
      chk(mail_pending, 8'h00);
      contend = 1;
      xfer(1, 11'h155, 8'hA5, 40);
      chk(early, 8'h00);
      contend = 1;
      xfer(0, 11'h155, 8'h00, 40);
      chk(early, 8'h00);
      chk(q, 8'hA5);
      print_verdict();
   end
endmodule
